// ===== tib_pkg.sv
package tib_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_BDTR       = 8'h44;
    localparam logic [7:0]  OFS_AF1        = 8'h60;
    localparam logic [7:0]  OFS_TISEL      = 8'h68;
    localparam int          TIMER_SEL_BIT  = 8;
    localparam int          ADDR_W         = 9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          AF1_EN_BIT     = 0;
    localparam int          AF1_POL_BIT    = 9;
    localparam int          BDTR_LOCK_LSB  = 8;
    localparam int          BDTR_BKE_BIT   = 12;
    localparam int          BDTR_BKP_BIT   = 13;
    localparam int          SEL_W          = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        AF1_EN_RESET   = 1'h1;
    localparam logic        AF1_POL_RESET  = 1'h0;
    localparam logic [3:0]  TISEL_RESET    = 4'h0;
    localparam logic [1:0]  LOCK_OFF       = 2'h0;

    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    localparam logic [3:0]  SEL_PIN        = 4'h0;
    localparam logic [3:0]  SEL1_LSI       = 4'h1;
    localparam logic [3:0]  SEL1_LSE       = 4'h2;
    localparam logic [3:0]  SEL1_RTC       = 4'h3;
    localparam logic [3:0]  SEL2_HSE32     = 4'h2;
    localparam logic [3:0]  SEL2_MCO       = 4'h3;

    // ------------------------------------------------------------
    // Synchronised input positions
    // ------------------------------------------------------------
    localparam int          IN_PIN1        = 0;
    localparam int          IN_LSI         = 1;
    localparam int          IN_LSE         = 2;
    localparam int          IN_RTC         = 3;
    localparam int          IN_PIN2        = 4;
    localparam int          IN_HSE32       = 5;
    localparam int          IN_MCO         = 6;
    localparam int          IN_BRK1        = 7;
    localparam int          IN_BRK2        = 8;
    localparam int          IN_W           = 9;
endpackage

// ===== tib_sync.sv
module tib_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    if (W < 1) begin
        $error("tib_sync: W must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] val;
    } tib_sync_t;

    tib_sync_t s_q;
    tib_sync_t s_d;

    // ------------------------------------------------------------
    // Three stages; value moves once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        s_d.ff1 = din;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        for (int i = 0; i < W; i++) begin
            if (s_q.ff2[i] == s_q.ff3[i]) begin
                s_d.val[i] = s_q.ff3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.val;
endmodule

// ===== tib_top.sv
// Contract
// [RULE1] Timer 1 selector: 0 pin, 1 LOW_SPEED_INTERNAL_OSC osc, 2 LOW_SPEED_EXTERNAL_OSC osc, 3 RTC wakeup.
// [RULE2] Timer 2 selector: 0 pin, 1 none, 2 HIGH_SPEED_EXTERNAL_CLOCK/32, 3 clock output.
// [RULE3] Break polarity bit 0 means active low, 1 active high.
// [RULE4] Software keeps break polarity bit in step with main break polarity.
// [RULE5] Enabled external break is OR-ed into combined break, else ignored.
// [RULE6] Break enable and polarity writes ignored while lock level nonzero.
// [RULE7] Software writes reserved bits with their reset values.
// [RULE8] Registers are reachable with 16-bit accesses at their offsets.
// [RULE9] Break register resets to 0x1: enabled, active low.
// [RULE10] Input selection register resets to zero: channel pin selected.
// [RULE11] Lock 00 protects nothing; 01, 10, 11 include level 1.
// [RULE12] Lock field takes one write after reset, then stays frozen.
// [RULE13] Selected source feeds the channel 1 input path.
// [RULE14] Reserved selector codes drive a constant inactive level.
module tib_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        firstTimerChannelPin,
    input  wire logic        secondTimerChannelPin,
    input  wire logic        lowSpeedInternalOsc,
    input  wire logic        lowSpeedExternalOsc,
    input  wire logic        rtcWakeup,
    input  wire logic        highSpeedExternalClockDiv32,
    input  wire logic        clockOutputSignal,
    input  wire logic [1:0]  externalBreakInput,
    input  wire logic [1:0]  otherBreakSources,
    output logic      [1:0]  channel1TimerInput,
    output logic      [1:0]  combinedBreakSignal
);
    typedef struct packed {
        logic [1:0]                        extBreakEnable;
        logic [1:0]                        extBreakPolarity;
        logic [1:0][tib_pkg::SEL_W-1:0]    ch1SourceSelect;
        logic [1:0][1:0]                   lockLevel;
        logic [1:0]                        lockWritten;
        logic [1:0]                        mainBreakEnable;
        logic [1:0]                        mainBreakPolarity;
        logic                              wrPend;
        logic [tib_pkg::ADDR_W-1:0]        wrAddr;
        logic [15:0]                       wrMask;
        logic [31:0]                       rdata;
        logic                              readyOut;
        logic [1:0]                        ch1In;
        logic [1:0]                        combined_break_signal;
    } tib_state_t;

    tib_state_t                 s_q;
    tib_state_t                 s_d;
    logic [tib_pkg::IN_W-1:0]   rawIn;
    logic [tib_pkg::IN_W-1:0]   syncIn;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign rawIn = {externalBreakInput[1], externalBreakInput[0], clockOutputSignal,
                    highSpeedExternalClockDiv32, secondTimerChannelPin, rtcWakeup,
                    lowSpeedExternalOsc, lowSpeedInternalOsc, firstTimerChannelPin};

    tib_sync #(.W(tib_pkg::IN_W)) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   (rawIn),
        .dout  (syncIn)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        t;
        logic [7:0]  ofs;
        logic [15:0] wv;
        logic [15:0] mask;
        logic        extTerm;
        t       = 1'b0;
        ofs     = 8'h00;
        wv      = 16'h0000;
        mask    = 16'h0000;
        extTerm = 1'b0;
        s_d     = s_q;
        s_d.readyOut = 1'b1;

        // Write data phase
        t  = s_q.wrAddr[tib_pkg::TIMER_SEL_BIT];
        wv = hwdata[15:0] & s_q.wrMask;
        s_d.wrPend = 1'b0;
        if (s_q.wrPend) begin
            unique case ({s_q.wrAddr[7:2], 2'b00})
                tib_pkg::OFS_AF1: begin
                    if (s_q.lockLevel[t] == tib_pkg::LOCK_OFF) begin // [RULE6] [RULE11]
                        if (s_q.wrMask[tib_pkg::AF1_EN_BIT]) begin
                            s_d.extBreakEnable[t] = wv[tib_pkg::AF1_EN_BIT];
                        end
                        if (s_q.wrMask[tib_pkg::AF1_POL_BIT]) begin
                            s_d.extBreakPolarity[t] = wv[tib_pkg::AF1_POL_BIT];
                        end
                    end
                end
                tib_pkg::OFS_TISEL: begin
                    if (s_q.wrMask[0]) begin
                        s_d.ch1SourceSelect[t] = wv[tib_pkg::SEL_W-1:0];
                    end
                end
                tib_pkg::OFS_BDTR: begin
                    if (!s_q.lockWritten[t]) begin // [RULE12]
                        s_d.lockWritten[t] = 1'b1;
                        if (s_q.wrMask[tib_pkg::BDTR_LOCK_LSB]) begin
                            s_d.lockLevel[t] = wv[tib_pkg::BDTR_LOCK_LSB +: 2];
                        end
                    end
                    if (s_q.lockLevel[t] == tib_pkg::LOCK_OFF
                        && s_q.wrMask[tib_pkg::BDTR_BKE_BIT]) begin // [RULE11]
                        s_d.mainBreakEnable[t]   = wv[tib_pkg::BDTR_BKE_BIT];
                        s_d.mainBreakPolarity[t] = wv[tib_pkg::BDTR_BKP_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // Address phase; byte lanes of the low half-word carry all fields
        if (hsel && htrans[1] && hready) begin
            t   = haddr[tib_pkg::TIMER_SEL_BIT];
            ofs = {haddr[7:2], 2'b00};
            unique case (hsize)
                3'h0:    mask = haddr[1:0] == 2'h0 ? 16'h00ff
                              : (haddr[1:0] == 2'h1 ? 16'hff00 : 16'h0000);
                3'h1:    mask = haddr[1] ? 16'h0000 : 16'hffff; // [RULE8]
                default: mask = 16'hffff;
            endcase
            s_d.wrPend = hwrite;
            s_d.wrAddr = haddr[tib_pkg::ADDR_W-1:0];
            s_d.wrMask = mask;
            if (!hwrite) begin
                s_d.rdata = 32'h0000_0000;
                if (ofs == tib_pkg::OFS_AF1) begin
                    s_d.rdata[tib_pkg::AF1_EN_BIT]  = s_q.extBreakEnable[t];
                    s_d.rdata[tib_pkg::AF1_POL_BIT] = s_q.extBreakPolarity[t];
                end else if (ofs == tib_pkg::OFS_TISEL) begin
                    s_d.rdata[tib_pkg::SEL_W-1:0] = s_q.ch1SourceSelect[t];
                end else if (ofs == tib_pkg::OFS_BDTR) begin
                    s_d.rdata[tib_pkg::BDTR_LOCK_LSB +: 2] = s_q.lockLevel[t];
                    s_d.rdata[tib_pkg::BDTR_BKE_BIT] = s_q.mainBreakEnable[t];
                    s_d.rdata[tib_pkg::BDTR_BKP_BIT] = s_q.mainBreakPolarity[t];
                end
            end
        end

        // Channel 1 source routing
        unique case (s_q.ch1SourceSelect[0]) // [RULE1] [RULE13]
            tib_pkg::SEL_PIN:  s_d.ch1In[0] = syncIn[tib_pkg::IN_PIN1];
            tib_pkg::SEL1_LSI: s_d.ch1In[0] = syncIn[tib_pkg::IN_LSI];
            tib_pkg::SEL1_LSE: s_d.ch1In[0] = syncIn[tib_pkg::IN_LSE];
            tib_pkg::SEL1_RTC: s_d.ch1In[0] = syncIn[tib_pkg::IN_RTC];
            default:           s_d.ch1In[0] = 1'b0; // [RULE14]
        endcase
        unique case (s_q.ch1SourceSelect[1]) // [RULE2] [RULE13]
            tib_pkg::SEL_PIN:    s_d.ch1In[1] = syncIn[tib_pkg::IN_PIN2];
            tib_pkg::SEL2_HSE32: s_d.ch1In[1] = syncIn[tib_pkg::IN_HSE32];
            tib_pkg::SEL2_MCO:   s_d.ch1In[1] = syncIn[tib_pkg::IN_MCO];
            default:             s_d.ch1In[1] = 1'b0; // [RULE14]
        endcase

        // Break combine
        for (int i = 0; i < 2; i++) begin
            extTerm = s_q.extBreakPolarity[i] ? syncIn[tib_pkg::IN_BRK1 + i]
                                              : ~syncIn[tib_pkg::IN_BRK1 + i]; // [RULE3]
            s_d.combined_break_signal[i] = otherBreakSources[i] | (s_q.extBreakEnable[i] & extTerm); // [RULE5]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q                  <= '0;
            s_q.extBreakEnable   <= {2{tib_pkg::AF1_EN_RESET}};  // [RULE9]
            s_q.extBreakPolarity <= {2{tib_pkg::AF1_POL_RESET}}; // [RULE9]
            s_q.ch1SourceSelect  <= {2{tib_pkg::TISEL_RESET}};   // [RULE10]
            s_q.lockLevel        <= {2{tib_pkg::LOCK_OFF}};
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata              = s_q.rdata;
    assign hreadyout           = s_q.readyOut;
    assign hresp               = 1'b0;
    assign channel1TimerInput  = s_q.ch1In;
    assign combinedBreakSignal = s_q.combined_break_signal;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_rule1;
        s_q.ch1SourceSelect[0] == tib_pkg::SEL1_LSE
            |=> channel1TimerInput[0] == $past(syncIn[tib_pkg::IN_LSE]);
    endproperty
    a_rule1: assert property (p_rule1) else $error("timer1 source LOW_SPEED_EXTERNAL_OSC not routed"); // [RULE1]

    property p_rule2;
        s_q.ch1SourceSelect[1] == tib_pkg::SEL2_HSE32
            |=> channel1TimerInput[1] == $past(syncIn[tib_pkg::IN_HSE32]);
    endproperty
    a_rule2: assert property (p_rule2) else $error("timer2 source HIGH_SPEED_EXTERNAL_CLOCK/32 not routed"); // [RULE2]

    property p_rule3;
        (s_q.extBreakEnable[0] && !s_q.extBreakPolarity[0] && !otherBreakSources[0]
            && !syncIn[tib_pkg::IN_BRK1]) |=> combinedBreakSignal[0];
    endproperty
    a_rule3: assert property (p_rule3) else $error("active low break not seen"); // [RULE3]

    property p_rule5;
        (!s_q.extBreakEnable[1] && !otherBreakSources[1]) |=> !combinedBreakSignal[1];
    endproperty
    a_rule5: assert property (p_rule5) else $error("disabled break leaked"); // [RULE5]

    property p_rule6;
        (s_q.lockLevel[0] != tib_pkg::LOCK_OFF) |=> $stable(s_q.extBreakEnable[0])
            && $stable(s_q.extBreakPolarity[0]);
    endproperty
    a_rule6: assert property (p_rule6) else $error("locked break bits changed"); // [RULE6]

    property p_rule9;
        $fell(reset) |-> s_q.extBreakEnable == 2'h3 && s_q.extBreakPolarity == 2'h0;
    endproperty
    a_rule9: assert property (@(posedge clk) p_rule9) else $error("break reset value wrong"); // [RULE9]

    property p_rule10;
        $fell(reset) |-> s_q.ch1SourceSelect[0] == 4'h0 ##1 channel1TimerInput[0]
            == $past(syncIn[tib_pkg::IN_PIN1]);
    endproperty
    a_rule10: assert property (@(posedge clk) p_rule10) else $error("select reset wrong"); // [RULE10]

    property p_rule12;
        s_q.lockWritten[1] |=> $stable(s_q.lockLevel[1]) [*2];
    endproperty
    a_rule12: assert property (p_rule12) else $error("lock changed after first write"); // [RULE12]

    property p_rule14;
        s_q.ch1SourceSelect[1] == 4'h1 |=> !channel1TimerInput[1];
    endproperty
    a_rule14: assert property (p_rule14) else $error("reserved code not inactive"); // [RULE14]
endmodule

// ===== tib_far_side.sv
module tib_far_pins (
    input  wire logic       clk,
    input  wire logic [6:0] srcLevel,
    input  wire logic [1:0] breakLevel,
    output logic      [6:0] srcPins,
    output logic      [1:0] breakPins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Clock sources and break pins, changed just after an edge
    // ------------------------------------------------------------
    initial begin
        srcPins = 7'h00;
        breakPins = 2'h0;
    end
    always @(posedge clk) begin
        srcPins <= srcLevel;
        breakPins <= breakLevel;
    end
endmodule

// ===== timer_input_and_break_select_tb.sv
module timer_input_and_break_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, breakLevel, otherBreak, brkPins, chIn, brkOut;
    logic [2:0]  hsize;
    logic [6:0]  srcLevel, srcPins;
    int          n_mismatch, checked;

    tib_far_pins far (.clk(clk), .srcLevel(srcLevel), .breakLevel(breakLevel),
                      .srcPins(srcPins), .breakPins(brkPins));
    tib_top dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .firstTimerChannelPin(srcPins[0]), .lowSpeedInternalOsc(srcPins[1]),
        .lowSpeedExternalOsc(srcPins[2]), .rtcWakeup(srcPins[3]),
        .secondTimerChannelPin(srcPins[4]), .highSpeedExternalClockDiv32(srcPins[5]),
        .clockOutputSignal(srcPins[6]), .externalBreakInput(brkPins),
        .otherBreakSources(otherBreak), .channel1TimerInput(chIn),
        .combinedBreakSignal(brkOut));

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        if (n >= 100) check("bus wait", 32'h0, 32'h1);
    endtask

    task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("bus response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic do_reset;
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values;
        for (int t = 0; t < 2; t++) begin
            bus(32'h60 + 32'h100 * t, 1'b0, 3'h2, 32'h0);
            check("break config reset", rd, 32'h1);
            bus(32'h68 + 32'h100 * t, 1'b0, 3'h2, 32'h0);
            check("input select reset", rd, 32'h0);
        end
        bus(32'h10, 1'b0, 3'h2, 32'h0);
        check("unmapped read", rd, 32'h0);
    endtask

    task automatic test_select(input int t);
        int e;
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
        foreach (codes[i]) begin
            e = (codes[i] > 3 || (t == 1 && codes[i] == 1)) ? -1 :
                (t == 0) ? codes[i] : (codes[i] == 0 ? 4 : codes[i] + 3);
            bus(32'h68 + 32'h100 * t, 1'b1, 3'h2, {28'h0, codes[i]});
            bus(32'h68 + 32'h100 * t, 1'b0, 3'h2, 32'h0);
            check("select readback", rd, {28'h0, codes[i]});
            for (int p = 0; p < 2; p++) begin
                srcLevel <= (e < 0) ? 7'h7f : (p == 1 ? ~(7'h1 << e) : (7'h1 << e));
                repeat (8) @(posedge clk);
                check("channel input", {31'h0, chIn[t]},
                      {31'h0, e >= 0 && p == 0});
            end
        end
        bus(32'h68 + 32'h100 * t, 1'b1, 3'h2, 32'h0);
    endtask

    task automatic test_break(input int t);
        logic en, pol;
        for (int k = 0; k < 4; k++) begin
            en = k[0];
            pol = k[1];
            bus(32'h60 + 32'h100 * t, 1'b1, 3'h2, {22'h0, pol, 8'h0, en});
            bus(32'h60 + 32'h100 * t, 1'b0, 3'h2, 32'h0);
            check("break config", rd, {22'h0, pol, 8'h0, en});
            for (int p = 0; p < 2; p++) begin
                breakLevel[t] <= p[0];
                repeat (8) @(posedge clk);
                check("break out", {31'h0, brkOut[t]},
                      {31'h0, en & (pol ? p[0] : ~p[0])});
                otherBreak[t] <= 1'b1;
                repeat (3) @(posedge clk);
                check("break other", {31'h0, brkOut[t]}, 32'h1);
                otherBreak[t] <= 1'b0;
            end
        end
        bus(32'h60 + 32'h100 * t, 1'b1, 3'h2, 32'h1);
        bus(32'h60 + 32'h100 * t, 1'b0, 3'h2, 32'h0);
        check("word write", rd, 32'h1);
    endtask

    task automatic test_lock;
        bus(32'h44, 1'b1, 3'h2, 32'h0);
        bus(32'h60, 1'b1, 3'h2, 32'h201);
        bus(32'h60, 1'b0, 3'h2, 32'h0);
        check("unlocked write", rd, 32'h201);
        bus(32'h44, 1'b1, 3'h2, 32'h2100);
        bus(32'h44, 1'b0, 3'h2, 32'h0);
        check("lock frozen off", rd & 32'h3300, 32'h2000);
        bus(32'h160, 1'b1, 3'h2, 32'h201);
        bus(32'h144, 1'b1, 3'h2, 32'h3100);
        bus(32'h160, 1'b1, 3'h2, 32'h0);
        bus(32'h160, 1'b0, 3'h2, 32'h0);
        check("locked write", rd, 32'h201);
        bus(32'h144, 1'b1, 3'h2, 32'h0);
        bus(32'h144, 1'b0, 3'h2, 32'h0);
        check("lock frozen on", rd & 32'h3300, 32'h3100);
        do_reset();
        test_reset_values();
        bus(32'h44, 1'b1, 3'h2, 32'h300);
        bus(32'h60, 1'b1, 3'h2, 32'h200);
        bus(32'h60, 1'b0, 3'h2, 32'h0);
        check("level three write", rd, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic test_done;
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 30000);
        n_mismatch++;
        test_done();
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        srcLevel = 7'h00;
        breakLevel = 2'h0;
        otherBreak = 2'h0;
        n_mismatch = 0;
        checked = 0;
        @(posedge clk);
        do_reset();
        test_reset_values();
        test_select(0);
        test_select(1);
        test_break(0);
        test_break(1);
        test_lock();
        test_done();
    end
endmodule
